/* File: hdl/timer_buffer_valid_event_ctrl.sv */
`timescale 1ns/1ns
module timer_buffer_valid_event_ctrl (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic [timer_bv_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [timer_bv_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [timer_bv_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [timer_bv_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Timer core strobes
    input wire logic update,
    input wire logic [timer_bv_pkg::NUM_CMP-1:0] compare_buffer_write,
    input wire logic period_buffer_write,
    input wire logic prescale_tick,
    // Event input from outside the clock domain
    input wire logic event_in,
    // Status towards the timer core
    output logic [timer_bv_pkg::NUM_FLAGS-1:0] buf_valid_flags,
    output logic lock_update,
    output logic [timer_bv_pkg::COUNT_W-1:0] count_value,
    output logic count_dir
);

    // Write channel holding registers
    logic aw_held_q;
    logic [timer_bv_pkg::ADDR_W-1:0] aw_addr_q;
    logic w_held_q;
    logic [timer_bv_pkg::DATA_W-1:0] w_data_q;
    logic [3:0] w_strb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;

    // Read channel registers
    logic rvalid_q;
    logic [timer_bv_pkg::DATA_W-1:0] rdata_q;
    logic [1:0] rresp_q;

    // Register state
    logic [timer_bv_pkg::NUM_FLAGS-1:0] flags_q;
    logic [timer_bv_pkg::NUM_FLAGS-1:0] flags_d;
    logic [2:0] event_action_q;
    logic auto_lock_q;
    logic auto_lock_prev_q;
    logic [timer_bv_pkg::NUM_CMP-1:0] cmp_enable_q;
    logic lock_q;

    // Event synchroniser
    logic event_meta_q;
    logic event_sync_q;

    // Decoded write effects
    logic aw_take;
    logic w_take;
    logic wr_fire;
    logic ar_take;
    logic [timer_bv_pkg::IDX_W-1:0] wr_idx;
    logic [timer_bv_pkg::IDX_W-1:0] rd_idx;
    logic wr_low_lane;
    logic wr_mapped;
    logic rd_mapped;
    logic clr_wr;
    logic set_wr;
    logic event_control_wr;
    logic lockctl_wr;
    logic [timer_bv_pkg::NUM_FLAGS-1:0] sw_clear_mask;
    logic [timer_bv_pkg::NUM_FLAGS-1:0] sw_set_mask;
    logic [timer_bv_pkg::NUM_FLAGS-1:0] hw_set_mask;
    logic [timer_bv_pkg::NUM_FLAGS-1:0] update_clear_mask;
    logic all_enabled_valid;
    logic [timer_bv_pkg::NUM_CMP-1:0] cmp_flags;

    count_link_if link ();

    // Address decode
    assign wr_idx = aw_addr_q[timer_bv_pkg::ADDR_W-1:timer_bv_pkg::IDX_LSB];
    assign rd_idx = s_axi_araddr[timer_bv_pkg::ADDR_W-1:timer_bv_pkg::IDX_LSB];

    function automatic logic is_mapped(input logic [timer_bv_pkg::IDX_W-1:0] idx);
        is_mapped = (idx == timer_bv_pkg::IDX_BUF_VALID_CLEAR)
            || (idx == timer_bv_pkg::IDX_BUF_VALID_SET)
            || (idx == timer_bv_pkg::IDX_EVENT_CONTROL)
            || (idx == timer_bv_pkg::IDX_LOCK_CONTROL)
            || (idx == timer_bv_pkg::IDX_COUNT_VALUE);
    endfunction

    assign wr_mapped = is_mapped(wr_idx);
    assign rd_mapped = is_mapped(rd_idx);

    // Write channel: address and data taken in either order
    assign s_axi_awready = !aw_held_q && !bvalid_q;
    assign s_axi_wready = !w_held_q && !bvalid_q;
    assign aw_take = s_axi_awvalid && s_axi_awready;
    assign w_take = s_axi_wvalid && s_axi_wready;
    assign wr_fire = aw_held_q && w_held_q && !bvalid_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            aw_addr_q <= '0;
        end else if (aw_take) begin
            aw_held_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_held_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_q <= 1'b0;
            w_data_q <= '0;
            w_strb_q <= 4'h0;
        end else if (w_take) begin
            w_held_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_held_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q <= timer_bv_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_mapped ? timer_bv_pkg::RESP_OKAY : timer_bv_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    // Register writes only act on the low byte lane
    assign wr_low_lane = wr_fire && w_strb_q[0];
    assign clr_wr = wr_low_lane && (wr_idx == timer_bv_pkg::IDX_BUF_VALID_CLEAR);
    assign set_wr = wr_low_lane && (wr_idx == timer_bv_pkg::IDX_BUF_VALID_SET);
    assign event_control_wr = wr_low_lane && (wr_idx == timer_bv_pkg::IDX_EVENT_CONTROL);
    assign lockctl_wr = wr_low_lane && (wr_idx == timer_bv_pkg::IDX_LOCK_CONTROL);

    assign sw_clear_mask = clr_wr ? w_data_q[timer_bv_pkg::NUM_FLAGS-1:0] : '0;
    assign sw_set_mask = set_wr ? w_data_q[timer_bv_pkg::NUM_FLAGS-1:0] : '0;

    // Hardware set sources placed on the flag layout
    always_comb begin
        hw_set_mask = '0;
        hw_set_mask[timer_bv_pkg::PER_BV_BIT] = period_buffer_write;
        hw_set_mask[timer_bv_pkg::CMP0_BV_BIT] = compare_buffer_write[0];
        hw_set_mask[timer_bv_pkg::CMP1_BV_BIT] = compare_buffer_write[1];
        hw_set_mask[timer_bv_pkg::CMP2_BV_BIT] = compare_buffer_write[2];
    end

    assign update_clear_mask = update ? '1 : '0;

    // Sets are applied last so a coinciding write or set beats any clear
    assign flags_d = (flags_q & ~sw_clear_mask & ~update_clear_mask)
        | sw_set_mask | hw_set_mask;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flags_q <= timer_bv_pkg::FLAGS_RESET;
        end else begin
            flags_q <= flags_d;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            event_action_q <= timer_bv_pkg::EVENT_CONTROL_RESET[timer_bv_pkg::EVENT_ACTION_MSB:timer_bv_pkg::EVENT_ACTION_LSB];
        end else if (event_control_wr) begin
            event_action_q <= w_data_q[timer_bv_pkg::EVENT_ACTION_MSB:timer_bv_pkg::EVENT_ACTION_LSB];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            auto_lock_q <= 1'b0;
            cmp_enable_q <= timer_bv_pkg::CMP_EN_RESET;
        end else if (lockctl_wr) begin
            auto_lock_q <= w_data_q[timer_bv_pkg::AUTO_LOCK_BIT];
            cmp_enable_q <= w_data_q[timer_bv_pkg::CMP_EN_MSB:timer_bv_pkg::CMP_EN_LSB];
        end
    end

    // Auto lock: armed on enable and on each UPDATE, released once all enabled buffers are valid
    assign cmp_flags = flags_q[timer_bv_pkg::CMP2_BV_BIT:timer_bv_pkg::CMP0_BV_BIT];
    assign all_enabled_valid = &(cmp_flags | ~cmp_enable_q);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            auto_lock_prev_q <= 1'b0;
            lock_q <= 1'b0;
        end else begin
            auto_lock_prev_q <= auto_lock_q;
            if (!auto_lock_q) begin
                lock_q <= 1'b0;
            end else if (update || !auto_lock_prev_q) begin
                lock_q <= 1'b1;
            end else if (all_enabled_valid) begin
                lock_q <= 1'b0;
            end
        end
    end

    // Read channel
    assign s_axi_arready = !rvalid_q;
    assign ar_take = s_axi_arvalid && s_axi_arready;

    function automatic logic [timer_bv_pkg::DATA_W-1:0] read_word(
        input logic [timer_bv_pkg::IDX_W-1:0] idx
    );
        logic [timer_bv_pkg::DATA_W-1:0] w;
        w = '0;
        case (idx)
            timer_bv_pkg::IDX_BUF_VALID_CLEAR,
            timer_bv_pkg::IDX_BUF_VALID_SET: begin
                w[timer_bv_pkg::NUM_FLAGS-1:0] = flags_q;
            end
            timer_bv_pkg::IDX_EVENT_CONTROL: begin
                w[timer_bv_pkg::EVENT_ACTION_MSB:timer_bv_pkg::EVENT_ACTION_LSB] = event_action_q;
            end
            timer_bv_pkg::IDX_LOCK_CONTROL: begin
                w[timer_bv_pkg::AUTO_LOCK_BIT] = auto_lock_q;
                w[timer_bv_pkg::CMP_EN_MSB:timer_bv_pkg::CMP_EN_LSB] = cmp_enable_q;
                w[timer_bv_pkg::LOCK_STATUS_BIT] = lock_q;
            end
            timer_bv_pkg::IDX_COUNT_VALUE: begin
                w[timer_bv_pkg::COUNT_W-1:0] = link.count;
                w[timer_bv_pkg::DIR_BIT] = link.count_dir;
            end
            default: begin
                w = '0;
            end
        endcase
        read_word = w;
    endfunction

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= timer_bv_pkg::RESP_OKAY;
        end else if (ar_take) begin
            rvalid_q <= 1'b1;
            rdata_q <= read_word(rd_idx);
            rresp_q <= rd_mapped ? timer_bv_pkg::RESP_OKAY : timer_bv_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    // Two-stage synchroniser for the event input
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            event_meta_q <= 1'b0;
            event_sync_q <= 1'b0;
        end else begin
            event_meta_q <= event_in;
            event_sync_q <= event_meta_q;
        end
    end

    assign link.event_action = event_action_q;
    assign link.event_level = event_sync_q;
    assign link.prescale_tick = prescale_tick;

    event_counter u_counter (
        .aclk(aclk),
        .aresetn(aresetn),
        .link(link)
    );

    assign buf_valid_flags = flags_q;
    assign lock_update = lock_q;
    assign count_value = link.count;
    assign count_dir = link.count_dir;

endmodule

/* File: shared/timer_bv_pkg.sv */
package timer_bv_pkg;

    // Bus geometry: each register index maps to byte address index * 4
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int IDX_W = 6;
    localparam int IDX_LSB = 2;

    // Register indices
    localparam logic [IDX_W-1:0] IDX_BUF_VALID_CLEAR = 6'h06;
    localparam logic [IDX_W-1:0] IDX_BUF_VALID_SET = 6'h07;
    localparam logic [IDX_W-1:0] IDX_EVENT_CONTROL = 6'h09;
    localparam logic [IDX_W-1:0] IDX_LOCK_CONTROL = 6'h0b;
    localparam logic [IDX_W-1:0] IDX_COUNT_VALUE = 6'h0c;

    // Buffer-valid flag layout
    localparam int NUM_FLAGS = 4;
    localparam int NUM_CMP = 3;
    localparam int PER_BV_BIT = 0;
    localparam int CMP0_BV_BIT = 1;
    localparam int CMP1_BV_BIT = 2;
    localparam int CMP2_BV_BIT = 3;
    localparam logic [NUM_FLAGS-1:0] FLAGS_RESET = 4'h0;

    // Event control layout
    localparam int EVENT_ACTION_LSB = 1;
    localparam int EVENT_ACTION_MSB = 3;
    localparam logic [7:0] EVENT_CONTROL_RESET = 8'h00;

    // Lock control layout
    localparam int AUTO_LOCK_BIT = 0;
    localparam int CMP_EN_LSB = 1;
    localparam int CMP_EN_MSB = 3;
    localparam int LOCK_STATUS_BIT = 4;
    localparam logic [NUM_CMP-1:0] CMP_EN_RESET = 3'h0;

    // Count readout layout
    localparam int COUNT_W = 16;
    localparam int DIR_BIT = 16;
    localparam logic [COUNT_W-1:0] COUNT_RESET = 16'h0000;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        count_rising_edge = 3'b000,
        count_both_edges = 3'b001,
        count_while_high = 3'b010,
        count_direction_by_event = 3'b011
    } event_action_t;

endpackage

/* File: shared/count_link_if.sv */
`timescale 1ns/1ns
interface count_link_if;
    logic [2:0] event_action;
    logic event_level;
    logic prescale_tick;
    logic [timer_bv_pkg::COUNT_W-1:0] count;
    logic count_dir;

    modport ctrl (
        output event_action,
        output event_level,
        output prescale_tick,
        input count,
        input count_dir
    );

    modport counter (
        input event_action,
        input event_level,
        input prescale_tick,
        output count,
        output count_dir
    );
endinterface

/* File: hdl/event_counter.sv */
`timescale 1ns/1ns
module event_counter (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Control link
    count_link_if.counter link
);

    logic level_prev_q;
    logic [timer_bv_pkg::COUNT_W-1:0] count_q;
    logic [timer_bv_pkg::COUNT_W-1:0] count_d;
    logic dir_q;
    logic dir_d;
    logic rise;
    logic fall;

    assign rise = link.event_level && !level_prev_q;
    assign fall = !link.event_level && level_prev_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            level_prev_q <= 1'b0;
        end else begin
            level_prev_q <= link.event_level;
        end
    end

    always_comb begin
        count_d = count_q;
        dir_d = dir_q;
        case (link.event_action)
            timer_bv_pkg::count_rising_edge: begin
                if (rise) begin
                    count_d = count_q + 16'h0001;
                end
            end
            timer_bv_pkg::count_both_edges: begin
                if (rise || fall) begin
                    count_d = count_q + 16'h0001;
                end
            end
            timer_bv_pkg::count_while_high: begin
                if (link.prescale_tick && link.event_level) begin
                    count_d = count_q + 16'h0001;
                end
            end
            timer_bv_pkg::count_direction_by_event: begin
                if (link.prescale_tick) begin
                    dir_d = link.event_level;
                    if (link.event_level) begin
                        count_d = count_q - 16'h0001;
                    end else begin
                        count_d = count_q + 16'h0001;
                    end
                end
            end
            default: begin
                count_d = count_q;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_q <= timer_bv_pkg::COUNT_RESET;
            dir_q <= 1'b0;
        end else begin
            count_q <= count_d;
            dir_q <= dir_d;
        end
    end

    assign link.count = count_q;
    assign link.count_dir = dir_q;

endmodule

/* File: test/timer_bv_checker.sv */
`timescale 1ns/1ns
module timer_bv_checker (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [timer_bv_pkg::DATA_W-1:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Timer strobes and status
    input wire logic update,
    input wire logic [timer_bv_pkg::NUM_CMP-1:0] compare_buffer_write,
    input wire logic period_buffer_write,
    input wire logic [timer_bv_pkg::NUM_FLAGS-1:0] buf_valid_flags,
    input wire logic lock_update
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_update_clears: assert property (
        update && compare_buffer_write == 3'h0 && !period_buffer_write
        |=> buf_valid_flags == 4'h0 || $rose(s_axi_bvalid))
        else $error("flags survived an update");
    a_hw_write_sets: assert property (
        compare_buffer_write != 3'h0 || period_buffer_write
        |=> (buf_valid_flags & $past({compare_buffer_write, period_buffer_write}))
            == $past({compare_buffer_write, period_buffer_write}))
        else $error("buffer write did not set its flag");
    a_flags_have_cause: assert property (
        $changed(buf_valid_flags) |-> $past(update) || $past(period_buffer_write)
            || $past(compare_buffer_write) != 3'h0 || $rose(s_axi_bvalid))
        else $error("flags changed without cause");
    a_write_answer: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write response late");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    a_resp_holds: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_data_holds: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_busy_refuses: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");

    c_update_write: cover property (update && compare_buffer_write != 3'h0);
    c_lock_release: cover property ($fell(lock_update));
    c_read_stall: cover property (s_axi_rvalid && !s_axi_rready);
endmodule

bind timer_buffer_valid_event_ctrl timer_bv_checker chk_i (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .update(update), .compare_buffer_write(compare_buffer_write),
    .period_buffer_write(period_buffer_write), .buf_valid_flags(buf_valid_flags),
    .lock_update(lock_update)
);

/* File: test/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0] wstrb = 4'h0, flags;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, lock, cdir;
    logic [1:0] bresp, rresp;
    logic update = 1'b0, pbw = 1'b0, tick = 1'b0, ev = 1'b0;
    logic [2:0] cbw = 3'h0;
    logic [15:0] cnt, base;
    logic [15:0] deltas [5] = '{16'h0002, 16'h0004, 16'h0006, 16'hfffc, 16'h0000};
    int n_errors = 0;
    int checks_done = 0;

    timer_buffer_valid_event_ctrl uut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .update(update), .compare_buffer_write(cbw),
        .period_buffer_write(pbw), .prescale_tick(tick), .event_in(ev),
        .buf_valid_flags(flags), .lock_update(lock), .count_value(cnt), .count_dir(cdir)
    );

    initial begin
        forever #5 aclk = ~aclk;
    end

    task wrap_up;
        $display("comparisons %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Selector: 0 arready, 1 rvalid, 2 bvalid
    task automatic wait_for(input int which);
        int n;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (n > 50) begin
                n_errors++;
                $display("[FAIL] %0t handshake wait ran out", $time);
                wrap_up;
            end
        end while (!(which == 0 ? arready : (which == 1 ? rvalid : bvalid)));
    endtask

    // Caller is always just past a rising edge
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
            input logic [1:0] er);
        logic aw_ok, w_ok;
        int n;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        n = 0;
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            aw_ok = aw_ok || (awvalid && awready);
            w_ok = w_ok || (wvalid && wready);
            if (aw_ok) awvalid <= 1'b0;
            if (w_ok) wvalid <= 1'b0;
            n++;
            if (n > 50 && !(aw_ok && w_ok)) begin
                n_errors++;
                $display("[FAIL] %0t write address or data never taken", $time);
                wrap_up;
            end
        end
        if (!bvalid) wait_for(2);
        bready <= 1'b1;
        @(posedge aclk);
        chk(32'(bresp), 32'(er));
        bready <= 1'b0;
    endtask

    task rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        araddr <= a;
        arvalid <= 1'b1;
        wait_for(0);
        arvalid <= 1'b0;
        wait_for(1);
        rready <= 1'b1;
        @(posedge aclk);
        chk(rdata, exp);
        chk(32'(rresp), 32'(er));
        rready <= 1'b0;
    endtask

    task rd_flags(input logic [3:0] exp);
        rd(8'h18, 32'(exp), 2'h0);
        rd(8'h1c, 32'(exp), 2'h0);
        chk(32'(flags), 32'(exp));
    endtask

    task strobe(input logic u, input logic [2:0] c, input logic p);
        update <= u;
        cbw <= c;
        pbw <= p;
        @(posedge aclk);
        update <= 1'b0;
        cbw <= 3'h0;
        pbw <= 1'b0;
        @(posedge aclk);
    endtask

    initial begin
        logic [3:0] acc;
        logic lvl;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(8'h18, 32'h0, 2'h0);
        rd(8'h1c, 32'h0, 2'h0);
        rd(8'h20, 32'h0, 2'h2);
        rd(8'h24, 32'h0, 2'h0);
        rd(8'h28, 32'h0, 2'h2);
        rd(8'h2c, 32'h0, 2'h0);
        rd(8'h30, 32'h0, 2'h0);
        rd(8'h3c, 32'h0, 2'h2);
        $display("test reset values done");

        wr(8'h1c, 32'h5, 4'hf, 2'h0);
        rd_flags(4'h5);
        wr(8'h18, 32'h4, 4'hf, 2'h0);
        rd_flags(4'h1);
        wr(8'h1c, 32'hfa, 4'hf, 2'h0);
        rd_flags(4'hb);
        wr(8'h1c, 32'h4, 4'h0, 2'h0);
        wr(8'h3c, 32'hf, 4'hf, 2'h2);
        rd_flags(4'hb);
        wr(8'h18, 32'hf0f, 4'hf, 2'h0);
        rd_flags(4'h0);
        $display("test software access done");

        acc = 4'h0;
        for (int i = 0; i < 3; i++) begin
            strobe(1'b0, 3'(1 << i), 1'b0);
            acc = acc | 4'(2 << i);
            chk(32'(flags), 32'(acc));
        end
        strobe(1'b0, 3'h0, 1'b1);
        rd_flags(4'hf);
        strobe(1'b1, 3'h0, 1'b0);
        chk(32'(flags), 32'h0);
        wr(8'h1c, 32'hf, 4'hf, 2'h0);
        strobe(1'b1, 3'h2, 1'b0);
        chk(32'(flags), 32'h4);
        strobe(1'b1, 3'h0, 1'b1);
        chk(32'(flags), 32'h1);
        strobe(1'b1, 3'h0, 1'b0);
        $display("test hardware strobes done");

        wr(8'h24, 32'hff, 4'hf, 2'h0);
        rd(8'h24, 32'he, 2'h0);
        for (int m = 0; m < 5; m++) begin
            wr(8'h24, 32'(m * 2), 4'hf, 2'h0);
            rd(8'h24, 32'(m * 2), 2'h0);
            base = cnt;
            for (int p = 0; p < 4; p++) begin
                lvl = (p % 2) == 0;
                ev <= lvl;
                repeat (5) @(posedge aclk);
                tick <= 1'b1;
                repeat (lvl ? 3 : 1) @(posedge aclk);
                tick <= 1'b0;
                repeat (2) @(posedge aclk);
                if (m == 3) chk(32'(cdir), 32'(lvl));
            end
            chk(32'(cnt), 32'(16'(base + deltas[m])));
            rd(8'h30, 32'(16'(base + deltas[m])), 2'h0);
        end
        $display("test event actions done");

        wr(8'h2c, 32'h3, 4'hf, 2'h0);
        repeat (2) @(posedge aclk);
        chk(32'(lock), 32'h1);
        rd(8'h2c, 32'h13, 2'h0);
        strobe(1'b0, 3'h1, 1'b0);
        @(posedge aclk);
        chk(32'(lock), 32'h0);
        strobe(1'b1, 3'h0, 1'b0);
        @(posedge aclk);
        chk(32'(lock), 32'h1);
        wr(8'h2c, 32'h0, 4'hf, 2'h0);
        repeat (2) @(posedge aclk);
        chk(32'(lock), 32'h0);
        $display("test lock update done");
        wrap_up;
    end
endmodule
